// ===== hw/dbt_edge_sync.sv
// module: three-stage synchroniser with agreement filter and rising-edge pulse
`default_nettype none

module dbt_edge_sync (
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic src_in,
    output logic      rise_out
);
    logic s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff;
    logic nxt_lvl, nxt_rise;

    // a level is accepted only once stages two and three agree
    always_comb begin
        nxt_lvl  = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
        nxt_rise = nxt_lvl & ~lvl_ff;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_ff   <= 1'b0;
            s2_ff   <= 1'b0;
            s3_ff   <= 1'b0;
            lvl_ff  <= 1'b0;
            rise_ff <= 1'b0;
        end else begin
            s1_ff   <= src_in;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            lvl_ff  <= nxt_lvl;
            rise_ff <= nxt_rise;
        end
    end

    assign rise_out = rise_ff;

endmodule : dbt_edge_sync

`default_nettype wire

// ===== hw/dbt_pkg.sv
// package: register map, field layout and bus carriers of the dual byte timer
`default_nettype none

package dbt_pkg;

    // ************************************************************
    // register map (offsets are word indices, byte address is four times)
    // ************************************************************
    localparam int unsigned ADDR_W = 17;
    localparam int unsigned IDX_W  = 15;
    localparam logic [IDX_W-1:0] IDX_LOW_MATCH  = 15'h7f10;
    localparam logic [IDX_W-1:0] IDX_HIGH_MATCH = 15'h7f11;
    localparam logic [IDX_W-1:0] IDX_CONTROL    = 15'h7f12;
    localparam logic [IDX_W-1:0] IDX_PRESCALE   = 15'h7f13;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 15'h7f14;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 15'h7f15;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] RST_PRE  = 5'h00;
    localparam logic [1:0] RST_EVT  = 2'h0;

    // ************************************************************
    // timer_control fields
    // ************************************************************
    localparam int unsigned CTL_SOFT_STATE = 7;
    localparam int unsigned CTL_SOFT_FLAG  = 6;
    localparam int unsigned CTL_SOFT_EN    = 5;
    localparam int unsigned CTL_COUNT_CLOCK_SELECT_HI   = 4;
    localparam int unsigned CTL_COUNT_CLOCK_SELECT_LO   = 3;
    localparam int unsigned CTL_RUN        = 2;
    localparam int unsigned CTL_FLAG       = 1;
    localparam int unsigned CTL_EN         = 0;

    // ************************************************************
    // prescale_mode_control fields
    // ************************************************************
    localparam int unsigned PMC_MODE_HI = 7;
    localparam int unsigned PMC_MODE_LO = 5;
    localparam int unsigned PMC_PRE_HI  = 4;
    localparam int unsigned PMC_PRE_LO  = 0;

    // ************************************************************
    // event status bits, clock sources, counter limits
    // ************************************************************
    localparam int unsigned EVT_LOW  = 0;
    localparam int unsigned EVT_HIGH = 1;
    localparam logic [1:0] COUNT_CLOCK_SELECT_SYS  = 2'h0;
    localparam logic [1:0] COUNT_CLOCK_SELECT_RC   = 2'h1;
    localparam logic [1:0] COUNT_CLOCK_SELECT_OSCA = 2'h2;
    localparam logic [1:0] COUNT_CLOCK_SELECT_OSCB = 2'h3;
    localparam int unsigned NUM_SRC   = 3;
    localparam logic [7:0] CNT_TOP    = 8'hff;
    localparam logic [7:0] CNT_ZERO   = 8'h00;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } dbt_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dbt_apb_rsp_s;

endpackage : dbt_pkg

`default_nettype wire

// ===== hw/dbt_timer.sv
// module: dual byte timer with prescaler, two waveform outputs and apb registers
//
// Chosen here: register access over APB.
`default_nettype none

// Overview of operation
// - mode 0 chains both counters into one 16-bit timer behind prescaler
// - low counter clock selectable: system, rc, two sub oscillators
// - mode 0 holds both waveform outputs at zero
// - 8-bit low timer period is match plus one prescaled ticks
// - modes 1, 3, 7 toggle low wave once per low period
// - modes 1, 4, 6 high counter is system clock pwm, 256 cycles
// - modes 2, 6 low counter is prescaled pwm of 256 ticks
// - modes 4, 5 low counter plain timer, low wave zero
// - modes 5, 7 high counter match counter, high wave toggles
// - timer flag set each low period, request when enabled
// - software flag and enable pair also raise the request
// - control layout: state, soft flag, soft enable, clock, run, flag, enable
// - clock select 00 system, 01 rc, 10 osc a, 11 osc b
// - run clear stops and clears counters and prescaler; match clears counter outside pwm modes
// - match buffers follow register when stopped, reload at counter zero
// - prescaler emits match and restarts when count equals prescale field
module dbt_timer (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_n_in,
    input  wire dbt_pkg::dbt_apb_req_s apb_req_in,
    output dbt_pkg::dbt_apb_rsp_s      apb_rsp_out,
    input  wire logic                  rc_osc_in,
    input  wire logic                  sub_oscillator_a_in,
    input  wire logic                  sub_oscillator_b_in,
    output logic                       low_wave_out,
    output logic                       high_wave_out,
    output logic                       irq_out
);
    import dbt_pkg::*;

    // ************************************************************
    // mode decoding
    // ************************************************************
    function automatic logic lo_is_pwm(input logic [2:0] m);
        lo_is_pwm = (m == 3'h2) || (m == 3'h6);
    endfunction : lo_is_pwm

    function automatic logic lo_toggles(input logic [2:0] m);
        lo_toggles = (m == 3'h1) || (m == 3'h3) || (m == 3'h7);
    endfunction : lo_toggles

    function automatic logic hi_is_pwm(input logic [2:0] m);
        hi_is_pwm = (m == 3'h1) || (m == 3'h4) || (m == 3'h6);
    endfunction : hi_is_pwm

    function automatic logic hi_toggles(input logic [2:0] m);
        hi_toggles = (m == 3'h5) || (m == 3'h7);
    endfunction : hi_toggles

    logic [7:0] low_match_ff, high_match_ff, ctl_ff, pmc_ff;
    logic [1:0] stat_ff, mask_ff;
    logic [31:0] prdata_ff;
    logic [4:0] pre_ff;
    logic [7:0] lo_ff, hi_ff, lbuf_ff, hbuf_ff;
    logic       lwave_ff, hwave_ff;

    logic [7:0] nxt_low_match, nxt_high_match, nxt_ctl, nxt_pmc;
    logic [1:0] nxt_stat, nxt_mask;
    logic [31:0] nxt_prdata;
    logic [4:0] nxt_pre;
    logic [7:0] nxt_lo, nxt_hi, nxt_lbuf, nxt_hbuf;
    logic       nxt_lwave, nxt_hwave;

    logic [NUM_SRC-1:0] src_pins, src_rise;
    logic [2:0] mode;
    logic [4:0] pre_val;
    logic       run, tick, pre_match, lo_hit, lo_ovf, lo_evt;
    logic       hi_run8, hi_ovf, hi_hit, hi_evt, soft_state;
    logic [IDX_W-1:0] idx;
    logic       acc, wr, setup, hit;
    logic [31:0] rd_mux;

    // ************************************************************
    // clock source synchronisers
    // ************************************************************
    assign src_pins = {sub_oscillator_b_in, sub_oscillator_a_in, rc_osc_in};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            dbt_edge_sync u_sync (
                .ref_clk_in (ref_clk_in),
                .rst_n_in   (rst_n_in),
                .src_in     (src_pins[gi]),
                .rise_out   (src_rise[gi])
            );
        end
    endgenerate

    assign run     = ctl_ff[CTL_RUN];
    assign mode    = pmc_ff[PMC_MODE_HI:PMC_MODE_LO];
    assign pre_val = pmc_ff[PMC_PRE_HI:PMC_PRE_LO];

    // ************************************************************
    // counting datapath
    // ************************************************************
    always_comb begin
        case (ctl_ff[CTL_COUNT_CLOCK_SELECT_HI:CTL_COUNT_CLOCK_SELECT_LO])
            COUNT_CLOCK_SELECT_SYS:  tick = 1'b1;
            COUNT_CLOCK_SELECT_RC:   tick = src_rise[0];
            COUNT_CLOCK_SELECT_OSCA: tick = src_rise[1];
            COUNT_CLOCK_SELECT_OSCB: tick = src_rise[2];
            default:    tick = 1'b0;
        endcase
        pre_match = run & tick & (pre_ff == pre_val);
        lo_ovf    = pre_match & (lo_ff == CNT_TOP);
        if (mode == 3'h0) begin
            lo_hit = pre_match & ({hi_ff, lo_ff} == {hbuf_ff, lbuf_ff});
        end else begin
            lo_hit = pre_match & (lo_ff == lbuf_ff);
        end
        lo_evt  = lo_is_pwm(mode) ? lo_ovf : lo_hit;
        hi_run8 = run & (hi_is_pwm(mode) | hi_toggles(mode));
        hi_ovf  = hi_run8 & (hi_ff == CNT_TOP);
        hi_hit  = hi_run8 & (hi_ff == hbuf_ff);
        hi_evt  = hi_is_pwm(mode) ? hi_ovf : hi_hit;

        nxt_pre = !run ? RST_PRE : (pre_match ? RST_PRE : (tick ? pre_ff + 5'h01 : pre_ff));

        // low pwm runs free over 256 ticks
        nxt_lo = lo_ff;
        if (!run) begin
            nxt_lo = CNT_ZERO;
        end else if (pre_match) begin
            if (lo_hit && !lo_is_pwm(mode)) begin
                nxt_lo = CNT_ZERO;
            end else begin
                nxt_lo = lo_ff + 8'h01;
            end
        end

        // high byte counts low overflow in mode 0
        // high counter stopped in modes 2 and 3
        // high match counter on system clock
        nxt_hi = hi_ff;
        if (!run || mode == 3'h2 || mode == 3'h3) begin
            nxt_hi = CNT_ZERO;
        end else if (mode == 3'h0) begin
            if (lo_hit) begin
                nxt_hi = CNT_ZERO;
            end else if (lo_ovf) begin
                nxt_hi = hi_ff + 8'h01;
            end
        end else if (hi_toggles(mode) && hi_hit) begin
            nxt_hi = CNT_ZERO;
        end else begin
            nxt_hi = hi_ff + 8'h01;
        end

        // buffers track or reload at zero
        nxt_lbuf = (!run || lo_ff == CNT_ZERO) ? low_match_ff : lbuf_ff;
        nxt_hbuf = (!run || hi_ff == CNT_ZERO) ? high_match_ff : hbuf_ff;

        // modes 4 and 5 low wave idle
        // set on overflow, reset on match; set wins when equal
        nxt_lwave = 1'b0;
        if (run && lo_toggles(mode)) begin
            nxt_lwave = lo_hit ? ~lwave_ff : lwave_ff;
        end else if (run && lo_is_pwm(mode)) begin
            nxt_lwave = lwave_ff;
            if (lo_hit) begin
                nxt_lwave = 1'b0;
            end
            if (lo_ovf) begin
                nxt_lwave = 1'b1;
            end
        end

        nxt_hwave = 1'b0;
        if (run && hi_toggles(mode)) begin
            nxt_hwave = hi_hit ? ~hwave_ff : hwave_ff;
        end else if (run && hi_is_pwm(mode)) begin
            nxt_hwave = hwave_ff;
            if (hi_hit) begin
                nxt_hwave = 1'b0;
            end
            if (hi_ovf) begin
                nxt_hwave = 1'b1;
            end
        end
    end

    // ************************************************************
    // apb slave and registers
    // ************************************************************
    assign idx   = apb_req_in.paddr[ADDR_W-1:2];
    assign acc   = apb_req_in.psel & apb_req_in.penable;
    assign setup = apb_req_in.psel & ~apb_req_in.penable;
    assign wr    = acc & apb_req_in.pwrite;
    assign soft_state = ctl_ff[CTL_SOFT_FLAG] & ctl_ff[CTL_SOFT_EN];

    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        case (idx)
            IDX_LOW_MATCH:  rd_mux[7:0] = low_match_ff;
            IDX_HIGH_MATCH: rd_mux[7:0] = high_match_ff;
            // state bit reads the soft pair product
            IDX_CONTROL:    rd_mux[7:0] = {soft_state, ctl_ff[6:0]};
            IDX_PRESCALE:   rd_mux[7:0] = pmc_ff;
            IDX_IRQ_STATUS: rd_mux[1:0] = stat_ff;
            IDX_IRQ_MASK:   rd_mux[1:0] = mask_ff;
            default:        hit = 1'b0;
        endcase

        // read data is latched in the setup cycle so pready can be fixed high
        nxt_prdata = setup ? rd_mux : prdata_ff;

        nxt_low_match  = (wr && idx == IDX_LOW_MATCH)  ? apb_req_in.pwdata[7:0] : low_match_ff;
        nxt_high_match = (wr && idx == IDX_HIGH_MATCH) ? apb_req_in.pwdata[7:0] : high_match_ff;
        nxt_pmc        = (wr && idx == IDX_PRESCALE)   ? apb_req_in.pwdata[7:0] : pmc_ff;
        nxt_mask       = (wr && idx == IDX_IRQ_MASK)   ? apb_req_in.pwdata[1:0] : mask_ff;

        nxt_ctl = ctl_ff;
        if (wr && idx == IDX_CONTROL) begin
            nxt_ctl = {1'b0, apb_req_in.pwdata[6:0]};
        end
        // hardware set beats a software clear
        // flag stays until software clears it
        nxt_ctl[CTL_FLAG] = nxt_ctl[CTL_FLAG] | lo_evt;

        // only bits already returned to software are cleared, so no event is lost
        nxt_stat = stat_ff;
        if (acc && !apb_req_in.pwrite && idx == IDX_IRQ_STATUS) begin
            nxt_stat = stat_ff & ~prdata_ff[1:0];
        end
        nxt_stat[EVT_LOW]  = nxt_stat[EVT_LOW] | lo_evt;
        nxt_stat[EVT_HIGH] = nxt_stat[EVT_HIGH] | hi_evt;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_match_ff  <= RST_BYTE;
            high_match_ff <= RST_BYTE;
            ctl_ff        <= RST_BYTE;
            pmc_ff        <= RST_BYTE;
            stat_ff       <= RST_EVT;
            mask_ff       <= RST_EVT;
            prdata_ff     <= 32'h0000_0000;
            pre_ff        <= RST_PRE;
            lo_ff         <= RST_BYTE;
            hi_ff         <= RST_BYTE;
            lbuf_ff       <= RST_BYTE;
            hbuf_ff       <= RST_BYTE;
            lwave_ff      <= 1'b0;
            hwave_ff      <= 1'b0;
        end else begin
            low_match_ff  <= nxt_low_match;
            high_match_ff <= nxt_high_match;
            ctl_ff        <= nxt_ctl;
            pmc_ff        <= nxt_pmc;
            stat_ff       <= nxt_stat;
            mask_ff       <= nxt_mask;
            prdata_ff     <= nxt_prdata;
            pre_ff        <= nxt_pre;
            lo_ff         <= nxt_lo;
            hi_ff         <= nxt_hi;
            lbuf_ff       <= nxt_lbuf;
            hbuf_ff       <= nxt_hbuf;
            lwave_ff      <= nxt_lwave;
            hwave_ff      <= nxt_hwave;
        end
    end

    assign apb_rsp_out         = '{prdata:  prdata_ff,
                                   pready:  1'b1,
                                   pslverr: acc & ~hit};
    assign low_wave_out        = lwave_ff;
    assign high_wave_out       = hwave_ff;

    // request while any pair is set
    assign irq_out = (ctl_ff[CTL_FLAG] & ctl_ff[CTL_EN]) | soft_state | (|(stat_ff & mask_ff));

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence hi_pwm_wrap_s;
        run && hi_is_pwm(mode) && hi_ff == CNT_TOP && $stable(mode) ##1 hi_ff == CNT_ZERO;
    endsequence

    pre_restart_a: assert property (pre_match |=> pre_ff == RST_PRE)
        else $error("prescaler did not restart after match");
    stop_clear_a: assert property (!run |=> lo_ff == 0 && hi_ff == 0 && pre_ff == 0)
        else $error("counters not cleared while stopped");
    mode0_quiet_a: assert property (mode == 3'h0 |=> !low_wave_out && !high_wave_out)
        else $error("waveform active in mode 0");
    lo_toggle_a: assert property (lo_toggles(mode) && lo_hit |=> low_wave_out != $past(lwave_ff))
        else $error("low wave did not toggle on match");
    hi_stop_a: assert property (mode == 3'h2 || mode == 3'h3 |=> hi_ff == 0 && !high_wave_out)
        else $error("high counter running in modes 2 or 3");
    hi_pwm_set_a: assert property (hi_pwm_wrap_s |-> high_wave_out)
        else $error("high pwm not set on overflow");
    lo_idle_a: assert property (mode == 3'h4 || mode == 3'h5 |=> !low_wave_out)
        else $error("low wave active in modes 4 or 5");
    flag_set_a: assert property (lo_evt |=> ctl_ff[CTL_FLAG] && (irq_out || !ctl_ff[CTL_EN]))
        else $error("timer flag not set on period event");
    soft_irq_a: assert property (soft_state |-> irq_out)
        else $error("soft pair did not raise interrupt");
    buf_follow_a: assert property (!run |=> lbuf_ff == $past(low_match_ff))
        else $error("low buffer not tracking while stopped");
    hi_toggle_a: assert property (hi_toggles(mode) && hi_hit |=> hi_ff == 0)
        else $error("high match counter did not restart");

endmodule : dbt_timer

`default_nettype wire

// ===== tb/dbt_testbench.sv
// testbench: apb driven checks of the dual byte timer modes, waveforms and interrupts
`default_nettype none
`define CHK(o, e) begin total_checks++; if ((o) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %h want %h", $time, (o), (e)); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import dbt_pkg::*;

    // ************************************************************
    // stimulus and bookkeeping
    // ************************************************************
    logic         ref_clk;
    logic         rst_n;
    dbt_apb_req_s req;
    dbt_apb_rsp_s rsp;
    logic         rc_osc;
    logic         osc_a;
    logic         osc_b;
    logic         low_wave;
    logic         high_wave;
    logic         irq;
    int           cyc;
    int           mismatches;
    int           total_checks;
    int           seed;
    int           t0;
    int           t1;
    int           t2;
    int           i;
    int           l;
    int           p;
    int           div [4] = '{1, 4, 6, 8};
    logic [32:0]  exp_q [$];
    logic [32:0]  obs;
    logic [32:0]  e_bus;
    logic [32:0]  e_obs;
    event         obs_ev;

    dbt_timer u_dbt_timer (
        .ref_clk_in          (ref_clk),
        .rst_n_in            (rst_n),
        .apb_req_in          (req),
        .apb_rsp_out         (rsp),
        .rc_osc_in           (rc_osc),
        .sub_oscillator_a_in (osc_a),
        .sub_oscillator_b_in (osc_b),
        .low_wave_out        (low_wave),
        .high_wave_out       (high_wave),
        .irq_out             (irq)
    );

    always #25 ref_clk = ~ref_clk;

    // slow sources of 4, 6 and 8 cycles, each level held at least two cycles
    always @(posedge ref_clk) begin
        cyc    <= cyc + 1;
        rc_osc <= (cyc % 4) < 2;
        osc_a  <= (cyc % 6) < 3;
        osc_b  <= (cyc % 8) < 4;
    end

    // ************************************************************
    // result watchers: oldest note against each result
    // ************************************************************
    always @(posedge ref_clk) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
            e_bus = exp_q.pop_front();
            `CHK({rsp.pslverr, rsp.prdata}, e_bus)
        end
    end

    always @(obs_ev) begin
        e_obs = exp_q.pop_front();
        `CHK(obs, e_obs)
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task results();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task fail();
        mismatches++;
        results();
    endtask : fail

    task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        if (!wr) exp_q.push_back(e);
        @(posedge ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge ref_clk);
            if (rsp.pready === 1'b1) break;
        end
        if (n == 16) fail();
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic cfg(input logic [2:0] m, input logic [4:0] pr, input logic [7:0] lo,
                       input logic [7:0] hi, input logic [7:0] c);
        apb(1'b1, IDX_CONTROL, 32'h0, '0);
        apb(1'b1, IDX_LOW_MATCH, {24'h0, lo}, '0);
        apb(1'b1, IDX_HIGH_MATCH, {24'h0, hi}, '0);
        apb(1'b1, IDX_PRESCALE, {24'h0, m, pr}, '0);
        apb(1'b1, IDX_CONTROL, {24'h0, c}, '0);
    endtask : cfg

    function automatic logic sig(input int w);
        return (w == 0) ? low_wave : (w == 1) ? high_wave : irq;
    endfunction : sig

    // sampled on the falling edge so registered outputs have settled
    task automatic edge_to(input int w, input logic v, output int t);
        int n;
        for (n = 0; n < 20000 && sig(w) === v; n++) @(negedge ref_clk);
        for (n = 0; n < 20000 && sig(w) !== v; n++) @(negedge ref_clk);
        if (n == 20000) fail();
        t = cyc;
    endtask : edge_to

    task automatic observe(input int o, input int e);
        exp_q.push_back(33'(e));
        obs = 33'(o);
        ->obs_ev;
        #1;
    endtask : observe

    // first flip after a change is a start transient and is skipped
    task automatic tog(input int w, input int e);
        edge_to(w, !sig(w), t0);
        edge_to(w, !sig(w), t0);
        edge_to(w, !sig(w), t1);
        observe(t1 - t0, e);
    endtask : tog

    task automatic pwm(input int w, input int hi, input int per);
        edge_to(w, 1'b1, t0);
        edge_to(w, 1'b0, t1);
        edge_to(w, 1'b1, t2);
        observe(t1 - t0, hi);
        observe(t2 - t0, per);
    endtask : pwm

    initial begin
        #(50 * 100000);
        fail();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        req = '0;
        {rc_osc, osc_a, osc_b} = 3'h0;
        {cyc, mismatches, total_checks} = '0;
        seed = 32'h57a8;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) apb(1'b0, IDX_LOW_MATCH + IDX_W'(i), 32'h0, 33'(RST_BYTE));
        apb(1'b0, IDX_IRQ_MASK + 15'h1, 32'h0, {1'b1, 32'h0});
        cfg(3'd0, 5'd0, 8'h03, 8'h01, 8'h04);
        apb(1'b1, IDX_IRQ_MASK, 32'h1, '0);
        edge_to(2, 1'b1, t2);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0, 33'h1);
        edge_to(2, 1'b1, t1);
        observe(t1 - t2, ((1 << 8) + 3 + 1) * (0 + 1));
        `CHK({low_wave, high_wave}, 2'b00)
        apb(1'b1, IDX_IRQ_MASK, 32'h0, '0);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        apb(1'b1, IDX_CONTROL, 32'h61, '0);
        apb(1'b0, IDX_CONTROL, 32'h0, 33'he1);
        @(negedge ref_clk);
        `CHK(irq, 1'b1)
        apb(1'b1, IDX_CONTROL, 32'h0, '0);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        l = $random(seed) & 15;
        p = $random(seed) & 3;
        for (i = 0; i < 4; i++) begin
            cfg(3'd3, 5'(p), 8'(l), 8'h00, {3'b000, 2'(i), 3'b101});
            tog(0, (l + 1) * (p + 1) * div[i]);
            `CHK(high_wave, 1'b0)
        end
        apb(1'b0, IDX_CONTROL, 32'h0, 33'h1f);
        @(negedge ref_clk);
        `CHK(irq, 1'b1)
        apb(1'b1, IDX_CONTROL, 32'h1c, '0);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        cfg(3'd2, 5'd1, 8'h3f, 8'h00, 8'h04);
        pwm(0, (63 + 1) * (1 + 1), 256 * (1 + 1));
        `CHK(high_wave, 1'b0)
        cfg(3'd1, 5'(p), 8'(l), 8'h1f, 8'h04);
        pwm(1, 31 + 1, 256);
        tog(0, (l + 1) * (p + 1));
        cfg(3'd4, 5'd0, 8'h07, 8'h3f, 8'h04);
        pwm(1, 63 + 1, 256);
        `CHK(low_wave, 1'b0)
        cfg(3'd6, 5'd0, 8'h07, 8'h0f, 8'h04);
        pwm(0, 7 + 1, 256);
        pwm(1, 15 + 1, 256);
        cfg(3'd5, 5'd0, 8'h05, 8'h09, 8'h04);
        tog(1, 9 + 1);
        `CHK(low_wave, 1'b0)
        apb(1'b0, IDX_IRQ_STATUS, 32'h0, 33'h3);
        cfg(3'd7, 5'd2, 8'h05, 8'h04, 8'h04);
        apb(1'b0, IDX_PRESCALE, 32'h0, 33'he2);
        tog(1, 4 + 1);
        tog(0, (5 + 1) * (2 + 1));
        apb(1'b1, IDX_HIGH_MATCH, 32'h13, '0);
        tog(1, 19 + 1);
        apb(1'b1, IDX_CONTROL, 32'h0, '0);
        repeat (2) @(negedge ref_clk);
        `CHK({low_wave, high_wave}, 2'b00)
        results();
    end

endmodule : testbench

`undef CHK
`default_nettype wire
